// *** hw/alg_dev.sv ***
// converter back end: delay line, gain, offset trim, output, config port
`timescale 1ns/1ps
module alg_dev
(
   input  wire logic                      clk_in,
   input  wire logic                      nrst_in,
   input  wire logic [alg_pkg::WORD_W-1:0] adc_raw_in,
   output logic                           fast_mode_out,
   output logic [4:0]                     latency_out,
   alg_link_if.dev                        link
);
   import alg_pkg::*;

   // ------------------------------------------------------------
   // synchronisers for every pin coming off the link
   // ------------------------------------------------------------
   logic [5:0]        s1_q, s2_q, s3_q;
   logic [WORD_W-1:0] raw1_q, raw2_q;

   // s3 keeps the previous synced level for edge detection
   always_ff @(posedge clk_in or negedge nrst_in)
   begin
      if (!nrst_in)
      begin
         s1_q   <= 6'h01;
         s2_q   <= 6'h01;
         s3_q   <= 6'h01;
         raw1_q <= 14'h0000;
         raw2_q <= 14'h0000;
      end
      else
      begin
         s1_q   <= {link.sample_clk, link.adc_rst, link.cfg_sclk,
                    link.cfg_serial_in, 1'b0, link.cfg_select_n};
         s2_q   <= s1_q;
         s3_q   <= s2_q;
         raw1_q <= adc_raw_in;
         raw2_q <= raw1_q;
      end
   end

   logic smp_rise, smp_fall, rst_pin, sck_rise, sel_n;
   assign smp_rise = s2_q[5] & ~s3_q[5];
   assign smp_fall = ~s2_q[5] & s3_q[5];
   assign rst_pin  = s2_q[4];
   assign sck_rise = s2_q[3] & ~s3_q[3];
   assign sel_n    = s2_q[0];

   // ------------------------------------------------------------
   // serial configuration receiver
   // ------------------------------------------------------------
   logic [15:0] sh_q, sh_d;
   logic [4:0]  cnt_q, cnt_d;
   logic [1:0]  lat_q, lat_d;
   logic [3:0]  gain_q, gain_d;
   logic        offs_q, offs_d;
   logic [2:0]  fmt_q, fmt_d;
   logic [15:0] word;

   // address arrives first, msb first, sampled on clock rise
   always_comb
   begin
      sh_d   = sh_q;
      cnt_d  = cnt_q;
      lat_d  = lat_q;
      gain_d = gain_q;
      offs_d = offs_q;
      fmt_d  = fmt_q;
      word   = {sh_q[14:0], s2_q[2]};
      if (rst_pin)
      begin
         // reset pin holds every setting at its default [R4]
         cnt_d  = 5'h00;
         lat_d  = 2'h0;
         gain_d = 4'h0;
         offs_d = 1'b0;
         fmt_d  = 3'h0;
      end
      else if (sel_n)
         cnt_d = 5'h00;      // a short frame is dropped
      else if (sck_rise)
      begin
         sh_d  = word;
         cnt_d = cnt_q + 5'h01;
         if (cnt_q == 5'(CFG_BITS - 1))
         begin
            cnt_d = 5'h00;                                   // [R11]
            case (word[15:8])
               ADDR_LAT:
               begin
                  lat_d = word[1:0];
                  if (word[BIT_FPD] && !lat_q[BIT_FPD])
                     gain_d = 4'h0;                          // [R7]
               end
               ADDR_GAIN: gain_d = word[3:0];                // [R8]
               ADDR_OFFS: offs_d = word[BIT_OFFS];
               ADDR_FMT:  fmt_d  = word[2:0];
               default:   ;
            endcase
         end
      end
   end

   always_ff @(posedge clk_in or negedge nrst_in)
   begin
      if (!nrst_in)
      begin
         sh_q   <= 16'h0000;
         cnt_q  <= 5'h00;
         lat_q  <= 2'h0;                                      // [R4]
         gain_q <= 4'h0;
         offs_q <= 1'b0;
         fmt_q  <= 3'h0;
      end
      else
      begin
         sh_q   <= sh_d;
         cnt_q  <= cnt_d;
         lat_q  <= lat_d;
         gain_q <= gain_d;
         offs_q <= offs_d;
         fmt_q  <= fmt_d;
      end
   end

   // ------------------------------------------------------------
   // delay line and latency selection
   // ------------------------------------------------------------
   logic [WORD_W-1:0] line_q [DEPTH], line_d [DEPTH];
   logic [4:0]        lat;
   logic              fpd, offs_on;

   assign fpd     = lat_q[BIT_FPD];
   assign offs_on = fpd & offs_q;

   // functions cost extra stages; slow output clock one more
   always_comb
   begin
      if (!fpd)
         lat = LAT_FAST;                                      // [R2]
      else if (offs_on)
         lat = LAT_OFFS;                                      // [R5] [R17]
      else
         lat = LAT_GAIN;                                      // [R5] [R16]
      if (lat_q[BIT_SLOW])
         lat = lat + LAT_EXTRA;                                // [R3]
   end

   // one shared line for every path, so a latency change can
   // repeat or skip words but never swap their order
   always_comb
   begin
      for (int i = 0; i < DEPTH; i++)
         line_d[i] = line_q[i];
      if (smp_rise)
      begin
         line_d[0] = raw2_q;                                  // [R1]
         for (int i = 1; i < DEPTH; i++)
            line_d[i] = line_q[i-1];                          // [R1] [R19]
      end
   end

   always_ff @(posedge clk_in or negedge nrst_in)
   begin
      if (!nrst_in)
      begin
         for (int i = 0; i < DEPTH; i++)
            line_q[i] <= 14'h0000;
      end
      else
      begin
         for (int i = 0; i < DEPTH; i++)
            line_q[i] <= line_d[i];
      end
   end

   // ------------------------------------------------------------
   // offset estimate, gain and output coding
   // ------------------------------------------------------------
   logic signed [21:0] acc_q, acc_d;
   logic signed [15:0] smp, est, trim;
   logic signed [28:0] prod;
   logic signed [15:0] scaled;
   logic [3:0]         gcode;
   logic [WORD_W-1:0]  tap, coded;

   // leaky average of the incoming signed sample
   always_comb
   begin
      acc_d = acc_q;
      if (!offs_on)
         acc_d = 22'sh000000;
      else if (smp_rise)
         acc_d = acc_q + 22'(signed'({{2{~raw2_q[13]}}, raw2_q[12:0]}))
                 - (acc_q >>> OFFS_SHIFT);
   end

   always_ff @(posedge clk_in or negedge nrst_in)
   begin
      if (!nrst_in)
         acc_q <= 22'sh000000;
      else
         acc_q <= acc_d;
   end

   // raw word is offset binary; functions act on the signed value
   always_comb
   begin
      tap    = line_q[lat - 5'h01];
      smp    = 16'(signed'({~tap[13], ~tap[13], tap[12:0]}));
      est    = 16'(acc_q >>> OFFS_SHIFT);
      trim   = offs_on ? smp - est : smp;
      gcode  = (gain_q > GAIN_MAX) ? GAIN_MAX : gain_q;       // [R18]
      prod   = trim * signed'({1'b0, GAIN_TAB[gcode]});       // [R9]
      scaled = 16'(prod >>> GAIN_FRAC);
      if (scaled > POS_FS)
         scaled = POS_FS;
      else if (scaled < NEG_FS)
         scaled = NEG_FS;
      coded  = fpd ? scaled[13:0] ^ SIGN_FLIP : tap;          // [R2]
      if (fmt_q[BIT_TWOS])
         coded = coded ^ SIGN_FLIP;                           // [R10]
      if (fmt_q[BIT_NARROW])
         coded = coded & NARROW_MASK;                         // [R10]
   end

   // ------------------------------------------------------------
   // output register: cmos word, or ddr halves on the lanes
   // ------------------------------------------------------------
   logic [WORD_W-1:0] word_q, word_d, data_q, data_d;
   logic              dclk_q, dclk_d;
   logic [LANE_W-1:0] evens, odds;

   always_comb
   begin
      word_d = word_q;
      data_d = data_q;
      dclk_d = dclk_q;
      for (int i = 0; i < LANE_W; i++)
      begin
         evens[i] = coded[2*i];
         odds[i]  = word_q[2*i+1];
      end
      if (smp_rise)
      begin
         word_d = coded;
         dclk_d = 1'b0;
         data_d = fmt_q[BIT_DDR] ? WORD_W'(evens) : coded;    // [R10]
      end
      else if (smp_fall)
      begin
         dclk_d = 1'b1;
         if (fmt_q[BIT_DDR])
            data_d = WORD_W'(odds);
      end
   end

   always_ff @(posedge clk_in or negedge nrst_in)
   begin
      if (!nrst_in)
      begin
         word_q        <= 14'h0000;
         data_q        <= 14'h0000;
         dclk_q        <= 1'b0;
         fast_mode_out <= 1'b1;
         latency_out   <= LAT_FAST;
      end
      else
      begin
         word_q        <= word_d;
         data_q        <= data_d;
         dclk_q        <= dclk_d;
         fast_mode_out <= ~fpd;
         latency_out   <= lat;
      end
   end

   assign link.data     = data_q;
   assign link.data_clk = dclk_q;
endmodule : alg_dev

// *** hw/alg_pkg.sv ***
// constants shared by both ends of the converter back end and config link
//
// How it works
// [R1] sample on sample-clock rise, shift pipeline each edge
// [R2] fast path: raw word out after ten edges
// [R3] slow output clock adds one more edge
// [R4] any reset returns fast path, functions off
// [R5] digital functions lengthen the latency
// [R6] host sets fast_path_disable before other settings
// [R7] fast_path_disable also enables gain at 0 dB
// [R8] gain 0 to 6 dB in half-dB steps
// [R9] each gain step shrinks full scale proportionally
// [R10] 12/14-bit word, binary or twos, DDR or CMOS
// [R11] serial transfer: 8-bit address then 8-bit data
// [R12] host keeps serial clock at or below 20 MHz
// [R13] host pulses reset high for serial setup
// [R14] host reset pulse between 10 ns and 1 us
// [R15] host waits 100 ns before selecting
// [R16] gain only: sixteen edges latency
// [R17] gain plus offset correction: seventeen edges
// [R18] gain codes 0..12, code 0 is 0 dB
// [R19] one delay line for all paths, no reordering
package alg_pkg;
   // ------------------------------------------------------------
   // data path
   // ------------------------------------------------------------
   localparam int          WORD_W      = 14;
   localparam int          LANE_W      = WORD_W / 2;
   localparam int          DEPTH       = 18;
   localparam logic [4:0]  LAT_FAST    = 5'h0A;
   localparam logic [4:0]  LAT_GAIN    = 5'h10;
   localparam logic [4:0]  LAT_OFFS    = 5'h11;
   localparam logic [4:0]  LAT_EXTRA   = 5'h01;
   localparam logic [13:0] SIGN_FLIP   = 14'h2000;
   localparam logic [13:0] NARROW_MASK = 14'h3FFC;
   localparam int          OFFS_SHIFT  = 8;
   localparam int          GAIN_FRAC   = 10;
   localparam logic [3:0]  GAIN_MAX    = 4'hC;
   localparam logic signed [15:0] POS_FS = 16'sh1FFF;
   localparam logic signed [15:0] NEG_FS = -16'sh2000;
   // gain in 1/1024 units, one entry per half-dB step
   localparam logic [11:0] GAIN_TAB [0:12] = '{
      12'h400, 12'h43D, 12'h47D, 12'h4C1, 12'h509, 12'h556, 12'h5A7,
      12'h5FC, 12'h657, 12'h6B7, 12'h71D, 12'h789, 12'h7FB};
   // ------------------------------------------------------------
   // serial configuration map
   // ------------------------------------------------------------
   localparam int         CFG_BITS   = 16;
   localparam logic [7:0] ADDR_LAT   = 8'h01;
   localparam logic [7:0] ADDR_GAIN  = 8'h02;
   localparam logic [7:0] ADDR_OFFS  = 8'h03;
   localparam logic [7:0] ADDR_FMT   = 8'h04;
   localparam int         BIT_FPD    = 0;
   localparam int         BIT_SLOW   = 1;
   localparam int         BIT_OFFS   = 0;
   localparam int         BIT_TWOS   = 0;
   localparam int         BIT_DDR    = 1;
   localparam int         BIT_NARROW = 2;
   // ------------------------------------------------------------
   // host timing
   // ------------------------------------------------------------
   localparam int CLK_MHZ      = 100;
   localparam int SCLK_MAX_MHZ = 20;
   localparam int RST_PULSE_NS = 100;
   localparam int RST_WAIT_NS  = 100;
   localparam int SAMPLE_NS    = 160;
   localparam int SCLK_HALF    =
      (1000 * CLK_MHZ + 2 * SCLK_MAX_MHZ * 1000 - 1)
      / (2 * SCLK_MAX_MHZ * 1000);
   localparam int RST_CYC      = RST_PULSE_NS * CLK_MHZ / 1000;
   localparam int WAIT_CYC     = (RST_WAIT_NS * CLK_MHZ + 999) / 1000;
   localparam int SAMPLE_HALF  = SAMPLE_NS * CLK_MHZ / 2000;
endpackage : alg_pkg

// *** hw/alg_link_if.sv ***
// link between converter back end and capture / config host
`timescale 1ns/1ps
interface alg_link_if;
   logic                      sample_clk;
   logic                      adc_rst;
   logic                      cfg_select_n;
   logic                      cfg_sclk;
   logic                      cfg_serial_in;
   logic [alg_pkg::WORD_W-1:0] data;
   logic                      data_clk;

   modport dev (input sample_clk, adc_rst, cfg_select_n, cfg_sclk,
                cfg_serial_in, output data, data_clk);
   modport host (output sample_clk, adc_rst, cfg_select_n, cfg_sclk,
                 cfg_serial_in, input data, data_clk);
endinterface : alg_link_if

// *** hw/alg_host.sv ***
// capture receiver and serial configuration master
`timescale 1ns/1ps
module alg_host
(
   input  wire logic                       clk_in,
   input  wire logic                       nrst_in,
   input  wire logic                       reset_req_in,
   input  wire logic                       cmd_valid_in,
   input  wire logic [7:0]                 cmd_addr_in,
   input  wire logic [7:0]                 cmd_data_in,
   input  wire logic                       ddr_mode_in,
   output logic                            cmd_ready_out,
   output logic [alg_pkg::WORD_W-1:0]      word_out,
   output logic                            word_valid_out,
   alg_link_if.host                        link
);
   import alg_pkg::*;

   typedef enum {H_IDLE, H_RST, H_WAIT, H_LOW, H_HIGH, H_HOLD} alg_hst_e;

   // ------------------------------------------------------------
   // sample clock divider and configuration sequencer
   // ------------------------------------------------------------
   alg_hst_e    st_q, st_d;
   logic [7:0]  tmr_q, tmr_d, div_q, div_d;
   logic [4:0]  bit_q, bit_d;
   logic [15:0] sh_q, sh_d;
   logic        smp_q, smp_d, rst_q, rst_d, sel_q, sel_d;
   logic        sck_q, sck_d, sd_q, sd_d, rdy_q, rdy_d;

   always_comb
   begin
      st_d  = st_q;
      tmr_d = (tmr_q == 8'h00) ? 8'h00 : tmr_q - 8'h01;
      bit_d = bit_q;
      sh_d  = sh_q;
      rst_d = 1'b0;
      sel_d = sel_q;
      sck_d = sck_q;
      sd_d  = sd_q;
      rdy_d = 1'b0;
      div_d = div_q + 8'h01;
      smp_d = smp_q;
      if (div_q == 8'(SAMPLE_HALF - 1))
      begin
         div_d = 8'h00;
         smp_d = ~smp_q;    // divided sample clock, 160 ns period
      end
      case (st_q)
         H_IDLE:
         begin
            sel_d = 1'b1;
            sck_d = 1'b0;
            rdy_d = ~reset_req_in;
            if (reset_req_in)
            begin
               st_d  = H_RST;
               rst_d = 1'b1;                                  // [R13]
               tmr_d = 8'(RST_CYC - 1);                       // [R14]
            end
            else if (cmd_valid_in && rdy_q)
            begin
               st_d  = H_LOW;
               sel_d = 1'b0;
               sh_d  = {cmd_addr_in, cmd_data_in};            // [R11]
               sd_d  = cmd_addr_in[7];
               bit_d = 5'(CFG_BITS - 1);
               tmr_d = 8'(SCLK_HALF - 1);
            end
         end
         H_RST:
         begin
            rst_d = (tmr_q != 8'h00);                         // [R14]
            if (tmr_q == 8'h00)
            begin
               st_d  = H_WAIT;
               tmr_d = 8'(WAIT_CYC);                          // [R15]
            end
         end
         H_WAIT:
            if (tmr_q == 8'h00)
               st_d = H_IDLE;                                 // [R15]
         H_LOW:
            if (tmr_q == 8'h00)
            begin
               st_d  = H_HIGH;
               sck_d = 1'b1;
               tmr_d = 8'(SCLK_HALF - 1);                     // [R12]
            end
         H_HIGH:
            if (tmr_q == 8'h00)
            begin
               sck_d = 1'b0;
               tmr_d = 8'(SCLK_HALF - 1);                     // [R12]
               sh_d  = {sh_q[14:0], 1'b0};
               if (bit_q == 5'h00)
                  st_d = H_HOLD;
               else
               begin
                  st_d  = H_LOW;
                  bit_d = bit_q - 5'h01;
                  sd_d  = sh_q[14];
               end
            end
         H_HOLD:
            if (tmr_q == 8'h00)
            begin
               sel_d = 1'b1;
               st_d  = H_WAIT;
               tmr_d = 8'(SCLK_HALF - 1);
            end
         default: st_d = H_IDLE;
      endcase
   end

   always_ff @(posedge clk_in or negedge nrst_in)
   begin
      if (!nrst_in)
      begin
         st_q  <= H_IDLE;
         tmr_q <= 8'h00;
         div_q <= 8'h00;
         bit_q <= 5'h00;
         sh_q  <= 16'h0000;
         smp_q <= 1'b0;
         rst_q <= 1'b0;
         sel_q <= 1'b1;
         sck_q <= 1'b0;
         sd_q  <= 1'b0;
         rdy_q <= 1'b0;
      end
      else
      begin
         st_q  <= st_d;
         tmr_q <= tmr_d;
         div_q <= div_d;
         bit_q <= bit_d;
         sh_q  <= sh_d;
         smp_q <= smp_d;
         rst_q <= rst_d;
         sel_q <= sel_d;
         sck_q <= sck_d;
         sd_q  <= sd_d;
         rdy_q <= rdy_d;
      end
   end

   assign link.sample_clk    = smp_q;
   assign link.adc_rst       = rst_q;
   assign link.cfg_select_n  = sel_q;
   assign link.cfg_sclk      = sck_q;
   assign link.cfg_serial_in = sd_q;
   assign cmd_ready_out      = rdy_q;

   // ------------------------------------------------------------
   // capture: cmos on data clock rise, ddr evens then odds
   // ------------------------------------------------------------
   logic [WORD_W:0]   c1_q, c2_q;
   logic              cprev_q, vld_d;
   logic [WORD_W-1:0] ev_q, ev_d, out_d, dprev_q;

   // data and clock move together, so each ddr half is the value
   // that stood just before the clock edge, not the one after it
   always_comb
   begin
      ev_d  = ev_q;
      out_d = word_out;
      vld_d = 1'b0;
      if (c2_q[WORD_W] && !cprev_q)
      begin
         if (ddr_mode_in)
            ev_d = dprev_q;
         else
         begin
            out_d = c2_q[WORD_W-1:0];
            vld_d = 1'b1;
         end
      end
      else if (!c2_q[WORD_W] && cprev_q && ddr_mode_in)
      begin
         for (int i = 0; i < LANE_W; i++)
         begin
            out_d[2*i]   = ev_q[i];
            out_d[2*i+1] = dprev_q[i];
         end
         vld_d = 1'b1;
      end
   end

   always_ff @(posedge clk_in or negedge nrst_in)
   begin
      if (!nrst_in)
      begin
         c1_q           <= 15'h0000;
         c2_q           <= 15'h0000;
         cprev_q        <= 1'b0;
         ev_q           <= 14'h0000;
         dprev_q        <= 14'h0000;
         word_out       <= 14'h0000;
         word_valid_out <= 1'b0;
      end
      else
      begin
         c1_q           <= {link.data_clk, link.data};
         c2_q           <= c1_q;
         cprev_q        <= c2_q[WORD_W];
         dprev_q        <= c2_q[WORD_W-1:0];
         ev_q           <= ev_d;
         word_out       <= out_d;
         word_valid_out <= vld_d;
      end
   end
endmodule : alg_host

// *** sim/alg_link_sva.sv ***
// checker watching the link wires between device and host ends
`timescale 1ns/1ps
module alg_link_sva
(
   input wire logic                       clk_in,
   input wire logic                       nrst_in,
   input wire logic                       sample_clk,
   input wire logic                       adc_rst,
   input wire logic                       cfg_select_n,
   input wire logic                       cfg_sclk,
   input wire logic                       cfg_serial_in,
   input wire logic [alg_pkg::WORD_W-1:0] data,
   input wire logic                       data_clk
);
   import alg_pkg::*;
   logic [4:0] bits_q;
   logic [4:0] bits_d;
   logic [3:0] gap_q;
   logic [3:0] gap_d;
   logic       sclk_q;
   // ----
   // helper counters
   // ----
   // bits per frame, and idle cycles since config reset (saturates)
   always_comb
   begin
      bits_d = cfg_select_n ? 5'h00 : bits_q + {4'h0, cfg_sclk & ~sclk_q};
      gap_d  = adc_rst ? 4'h0 : gap_q + {3'h0, gap_q != 4'hF};
   end
   // power-up counts as long past any reset pulse
   always_ff @(posedge clk_in or negedge nrst_in)
   begin
      if (!nrst_in)
      begin
         bits_q <= 5'h00;
         gap_q  <= 4'hF;
         sclk_q <= 1'b0;
      end
      else
      begin
         bits_q <= bits_d;
         gap_q  <= gap_d;
         sclk_q <= cfg_sclk;
      end
   end
   default clocking cb @(posedge clk_in);
   endclocking
   default disable iff (!nrst_in);
   sequence s_high;
      sample_clk [*8] ##1 !sample_clk;
   endsequence
   sequence s_setup;
      !cfg_sclk [*3];
   endsequence
   smp_high_a: assert property ($rose(sample_clk) |-> s_high)
      else $error("sample clock high phase wrong");
   sclk_frame_a: assert property ($rose(cfg_sclk) |-> !cfg_select_n)
      else $error("serial clock outside frame");
   sclk_rate_a: assert property ($rose(cfg_sclk) |-> cfg_sclk [*3])
      else $error("serial clock too fast");
   sd_hold_a: assert property
      (cfg_sclk && $past(cfg_sclk) |-> $stable(cfg_serial_in))
      else $error("serial data moved while clock high");
   sel_setup_a: assert property ($fell(cfg_select_n) |-> s_setup)
      else $error("select to clock setup short");
   frame_len_a: assert property
      ($rose(cfg_select_n) |-> bits_q == CFG_BITS)
      else $error("frame bit count wrong");
   rst_pulse_a: assert property
      ($rose(adc_rst) |-> ##[1:100] !adc_rst)
      else $error("config reset pulse too long");
   rst_wait_a: assert property ($fell(cfg_select_n) |-> gap_q >= 4'hA)
      else $error("select too soon after config reset");
   word_edge_a: assert property ($changed(data) |-> $changed(data_clk))
      else $error("data moved without output clock");
endmodule : alg_link_sva

// *** sim/adc_latency_gain_control_test.sv ***
// testbench: both link ends joined, user sides driven and judged
`timescale 1ns/1ps
`define CHK(nm, e, g) \
   begin \
      check_count++; \
      if ((g) !== (e)) \
      begin \
         $display("unexpected %s exp %0h got %0h", nm, e, g); \
         n_mismatch++; \
      end \
   end
module adc_latency_gain_control_test;
   import alg_pkg::*;
   logic              clk_in = 1'b0;
   logic              nrst_in;
   logic              reset_req;
   logic              cmd_valid;
   logic [7:0]        cmd_addr;
   logic [7:0]        cmd_data;
   logic              ddr_mode;
   logic [WORD_W-1:0] adc_raw;
   logic              cmd_ready;
   logic [WORD_W-1:0] word;
   logic              word_valid;
   logic              fast_mode;
   logic [4:0]        latency;
   int                n_mismatch = 0;
   int                check_count = 0;
   int                cycles = 0;
   int                n;
   logic              hit;
   // ----
   // clock, ends and checker
   // ----
   always #5 clk_in = ~clk_in;
   alg_link_if link ();
   alg_dev alg_dev_inst (.clk_in(clk_in), .nrst_in(nrst_in),
      .adc_raw_in(adc_raw), .fast_mode_out(fast_mode),
      .latency_out(latency), .link(link));
   alg_host alg_host_inst (.clk_in(clk_in), .nrst_in(nrst_in),
      .reset_req_in(reset_req), .cmd_valid_in(cmd_valid),
      .cmd_addr_in(cmd_addr), .cmd_data_in(cmd_data),
      .ddr_mode_in(ddr_mode), .cmd_ready_out(cmd_ready),
      .word_out(word), .word_valid_out(word_valid), .link(link));
   alg_link_sva alg_link_sva_inst (.clk_in(clk_in), .nrst_in(nrst_in),
      .sample_clk(link.sample_clk), .adc_rst(link.adc_rst),
      .cfg_select_n(link.cfg_select_n), .cfg_sclk(link.cfg_sclk),
      .cfg_serial_in(link.cfg_serial_in), .data(link.data),
      .data_clk(link.data_clk));
   // a hang ends the run as a failure
   always @(posedge clk_in)
   begin
      cycles++;
      if (cycles == 40000)
      begin
         n_mismatch++;
         end_of_test();
      end
   end
   task automatic end_of_test;
      $display("checks %0d mismatches %0d", check_count, n_mismatch);
      if (n_mismatch == 0 && check_count > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask : end_of_test
   task automatic wait_ready;
      for (int i = 0; i < 300 && cmd_ready !== 1'b1; i++)
         @(negedge clk_in);
   endtask : wait_ready
   // one write; the wire is decoded here so bit order is checked too
   task automatic cfg_write(input logic [7:0] a, input logic [7:0] d);
      logic [15:0] sh;
      int          cnt;
      logic        prev;
      sh = 16'h0000;
      cnt = 0;
      prev = 1'b0;
      wait_ready();
      cmd_valid = 1'b1;
      cmd_addr = a;
      cmd_data = d;
      @(negedge clk_in);
      cmd_valid = 1'b0;
      // ready stays up one cycle after the take; let it fall first
      @(negedge clk_in);
      for (int i = 0; i < 300 && cmd_ready !== 1'b1; i++)
      begin
         @(negedge clk_in);
         if (link.cfg_sclk && !prev && !link.cfg_select_n)
         begin
            sh = {sh[14:0], link.cfg_serial_in};
            cnt++;
         end
         prev = link.cfg_sclk;
      end
      `CHK("frame", {a, d}, sh)
      `CHK("bits", CFG_BITS, cnt)
   endtask : cfg_write
   task automatic reset_dev;
      wait_ready();
      reset_req = 1'b1;
      @(negedge clk_in);
      reset_req = 1'b0;
      @(negedge clk_in);
      wait_ready();
      `CHK("fast", 1'b1, fast_mode)
      `CHK("lat", LAT_FAST, latency)
   endtask : reset_dev
   // fill the line with mid-scale, step to y, count sample rises to e
   task automatic measure(input logic [13:0] y, input logic [13:0] e);
      logic prev;
      n = 0;
      hit = 1'b0;
      prev = 1'b0;
      adc_raw = 14'h2000;
      repeat (640) @(negedge clk_in);
      @(negedge link.sample_clk);
      @(negedge clk_in);
      adc_raw = y;
      for (int i = 0; i < 800 && !hit; i++)
      begin
         @(negedge clk_in);
         if (link.sample_clk && !prev)
            n++;
         prev = link.sample_clk;
         hit = (word_valid === 1'b1 && word === e);
      end
   endtask : measure
   // ----
   // scenarios
   // ----
   task automatic t_fast;
      `CHK("fast", 1'b1, fast_mode)
      measure(14'h1234, 14'h1234);
      `CHK("word", 1'b1, hit)
      `CHK("delay", LAT_FAST + 1, n)
      cfg_write(ADDR_LAT, 8'h02);
      `CHK("lat", LAT_FAST + LAT_EXTRA, latency)
      measure(14'h1234, 14'h1234);
      `CHK("delay", LAT_FAST + LAT_EXTRA + 1, n)
      cfg_write(ADDR_LAT, 8'h00);
      $display("done fast path");
   endtask : t_fast
   // codes past the top step must clamp to it
   task automatic t_gain;
      logic [3:0] codes [3] = '{4'h2, 4'hC, 4'hF};
      cfg_write(ADDR_LAT, 8'h01);
      `CHK("fast", 1'b0, fast_mode)
      `CHK("lat", LAT_GAIN, latency)
      measure(14'h2400, 14'h2400);
      `CHK("word", 1'b1, hit)
      `CHK("delay", LAT_GAIN + 1, n)
      foreach (codes[i])
      begin
         cfg_write(ADDR_GAIN, {4'h0, codes[i]});
         measure(14'h2400, 14'h2000 +
            GAIN_TAB[codes[i] > GAIN_MAX ? GAIN_MAX : codes[i]]);
         `CHK("gain", 1'b1, hit)
      end
      cfg_write(ADDR_OFFS, 8'h01);
      `CHK("lat", LAT_OFFS, latency)
      cfg_write(ADDR_OFFS, 8'h00);
      cfg_write(ADDR_GAIN, 8'h00);
      $display("done gain");
   endtask : t_gain
   // twos complement, narrow word, then DDR capture
   task automatic t_format;
      logic [7:0]  fmts [3] = '{8'h01, 8'h04, 8'h02};
      logic [13:0] exps [3] = '{14'h0403, 14'h2400, 14'h2403};
      foreach (fmts[i])
      begin
         cfg_write(ADDR_FMT, fmts[i]);
         ddr_mode = fmts[i][BIT_DDR];
         measure(14'h2403, exps[i]);
         `CHK("format", 1'b1, hit)
      end
      cfg_write(ADDR_FMT, 8'h00);
      ddr_mode = 1'b0;
      $display("done format");
   endtask : t_format
   // gain set before the fast path is left must not survive
   task automatic t_misorder;
      reset_dev();
      cfg_write(ADDR_GAIN, 8'h05);
      cfg_write(ADDR_LAT, 8'h01);
      measure(14'h2400, 14'h2400);
      `CHK("word", 1'b1, hit)
      `CHK("delay", LAT_GAIN + 1, n)
      $display("done misorder");
   endtask : t_misorder
   initial
   begin
      nrst_in = 1'b0;
      reset_req = 1'b0;
      cmd_valid = 1'b0;
      cmd_addr = 8'h00;
      cmd_data = 8'h00;
      ddr_mode = 1'b0;
      adc_raw = 14'h2000;
      repeat (2) @(negedge clk_in);
      nrst_in = 1'b1;
      @(negedge clk_in);
      t_fast();
      t_gain();
      t_format();
      t_misorder();
      end_of_test();
   end
endmodule : adc_latency_gain_control_test
